// >>> timer_pkg.sv
// Package with port addresses, control word fields and types of the interval timer.
package timer_pkg;

	localparam int NUM_COUNTERS = 3;

	// I/O port addresses.
	localparam logic [7:0] CNT0_PORT = 8'h40;
	localparam logic [7:0] CNT1_PORT = 8'h41;
	localparam logic [7:0] CNT2_PORT = 8'h42;
	localparam logic [7:0] CTRL_PORT = 8'h43;

	// Control word field positions.
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 6;
	localparam int RW_MSB = 5;
	localparam int RW_LSB = 4;
	localparam int MODE_MSB = 3;
	localparam int MODE_LSB = 1;
	localparam int BCD_BIT = 0;

	// Read-back command fields: active-low count and status, counter mask.
	localparam int RB_NOCOUNT_BIT = 5;
	localparam int RB_NOSTAT_BIT = 4;
	localparam int RB_CNT_LSB = 1;

	// Codes of the counter select and byte access fields.
	localparam logic [1:0] SEL_READBACK = 2'h3;
	localparam logic [1:0] RW_LATCH = 2'h0;
	localparam logic [1:0] RW_LSB_ONLY = 2'h1;
	localparam logic [1:0] RW_MSB_ONLY = 2'h2;
	localparam logic [1:0] RW_BOTH = 2'h3;

	// Reset values.
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	typedef enum logic [2:0] {
		MODE_EOC = 3'b000,
		MODE_ONESHOT = 3'b001,
		MODE_RATE = 3'b010,
		MODE_SQUARE = 3'b011,
		MODE_SWSTROBE = 3'b100,
		MODE_HWSTROBE = 3'b101
	} mode_t;

	typedef struct packed {
		logic [1:0] rw;
		logic [2:0] mode;
		logic bcd;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = 6'h00;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} io_req_t;

endpackage

// >>> interval_timer.sv
// Three-channel 16-bit interval timer with its I/O port programming interface.
//
// Notes on behaviour
// - Three independent counters 0 to 2, each with a programmable, readable count.
// - Counter bytes are written and read at ports 40h, 41h and 42h.
// - Each counter port follows the settings last written to control port 43h.
// - Each 16-bit count moves over its port as a high and a low byte.
// - Control bits 7:6 select counter 0, 1, 2, or a read-back command.
// - Bits 5:4 give latch, low only, high only, or low then high.
// - Bits 3:1 choose mode 0 to 5; x10 is mode 2, x11 mode 3.
// - Modes: end of count, one-shot, rate, square wave, soft and hard strobe.
// - Counters count down, in 16-bit binary or in BCD.
// - Bit 0 of control and status selects binary (0) or BCD (1).
// - Once a control word is written, a new count may be written any time.
// - A new count takes effect at the point the mode defines.
// - After a read-back command with bit 4 clear, a port read returns that counter's status byte.
// - Status bit 7 equals the counter's output level.
// - Status bits 5:4 return the programmed byte access code.
// - Status bits 3:1 return the mode code exactly as written.
`timescale 1ns/1ps

module interval_timer
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Host I/O port access
	input timer_pkg::io_req_t ioReq,
	output logic [7:0] ioRdData,
	output logic ioRdValid,
	// Counter pins
	input wire logic [timer_pkg::NUM_COUNTERS-1:0] countClkPin,
	input wire logic [timer_pkg::NUM_COUNTERS-1:0] gatePin,
	output logic [timer_pkg::NUM_COUNTERS-1:0] counterOut
);
	import timer_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers.

	// One step down; in BCD each nibble borrows from the next, 0000 wraps to 9999.
	function automatic logic [15:0] cntDec(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic borrow;
		r = v - 16'h0001;
		borrow = 1'b1;
		if (bcd) begin
			r = v;
			for (int k = 0; k < 4; k++) begin
				if (borrow) begin
					if (r[4*k +: 4] == 4'h0) begin
						r[4*k +: 4] = 4'h9;
					end else begin
						r[4*k +: 4] = r[4*k +: 4] - 4'h1;
						borrow = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	// Modes 2 and 3 ignore bit 3 of the code.
	function automatic mode_t normMode(input logic [2:0] m);
		mode_t r;
		r = mode_t'(m);
		if (m[1]) begin
			r = mode_t'({2'b01, m[0]});
		end
		return r;
	endfunction

	// Rate and square wave modes reload on their own at terminal count.
	function automatic logic autoReload(input mode_t m);
		return (m == MODE_RATE) || (m == MODE_SQUARE);
	endfunction

	// One-shot and hardware strobe start only on a gate rising edge.
	function automatic logic gateTrig(input mode_t m);
		return (m == MODE_ONESHOT) || (m == MODE_HWSTROBE);
	endfunction

	// Modes 0 and 4 load a written count at the next count clock without a trigger.
	function automatic logic loadOnWrite(input mode_t m);
		return (m == MODE_EOC) || (m == MODE_SWSTROBE);
	endfunction

	// Picks the high or the low byte of a count.
	function automatic logic [7:0] pickByte(input logic [15:0] v, input logic high);
		return high ? v[15:8] : v[7:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and port decode.

	logic [NUM_COUNTERS-1:0] clkS1, clkS2, clkS3;
	logic [NUM_COUNTERS-1:0] gateS1, gateS2, gateS3;
	logic [NUM_COUNTERS-1:0] tick, gateRise;
	logic [7:0] rdByte [NUM_COUNTERS];
	logic [7:0] rdMux;
	logic ctrlWr;
	logic [1:0] wrSel, wrRw;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clkS1 <= '0;
			clkS2 <= '0;
			clkS3 <= '0;
			gateS1 <= '0;
			gateS2 <= '0;
			gateS3 <= '0;
		end else begin
			clkS1 <= countClkPin;
			clkS2 <= clkS1;
			clkS3 <= clkS2;
			gateS1 <= gatePin;
			gateS2 <= gateS1;
			gateS3 <= gateS2;
		end
	end

	// Only the edge detectors read the third stage, so no logic sees a metastable first stage.
	// Counting happens on the rising edge of each counter's clock pin.
	assign tick = clkS2 & ~clkS3;
	assign gateRise = gateS2 & ~gateS3;

	assign ctrlWr = ioReq.wr && (ioReq.addr == CTRL_PORT);
	assign wrSel = ioReq.wdata[SEL_MSB:SEL_LSB];
	assign wrRw = ioReq.wdata[RW_MSB:RW_LSB];

	// Port 43h is write-only, so reading it returns the unmapped value.
	assign rdMux = (ioReq.addr == CNT0_PORT) ? rdByte[0] :
		(ioReq.addr == CNT1_PORT) ? rdByte[1] :
		(ioReq.addr == CNT2_PORT) ? rdByte[2] : UNMAPPED_READ;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ioRdData <= BYTE_RESET;
			ioRdValid <= 1'b0;
		end else begin
			ioRdValid <= ioReq.rd;
			if (ioReq.rd) begin
				ioRdData <= rdMux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter channels.

	for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
		ctrl_t ctrlR;
		logic [15:0] crR, ceR, olR;
		logic [7:0] stR;
		logic olValidR, stValidR, wrHighR, rdHighR;
		logic nullR, loadR, armR, runR, outR, trigR;
		logic portHit, cntWr, cntRd, ctrlHit, latchCmd, rbHit, rbCount, rbStat;
		logic cntDone, rdHigh, rdLast, isStrobe, loadNow;
		logic [15:0] crNew, rdSrc, dec1, dec2;
		mode_t md, wrMd;
		logic stbRun, trigMd, reloadMd, loadOnCnt, latchGo, statGo;
		logic [7:0] stNew;

		assign portHit = ioReq.addr == (CNT0_PORT + 8'(i));
		assign cntWr = ioReq.wr && portHit;
		assign cntRd = ioReq.rd && portHit;
		assign ctrlHit = ctrlWr && (wrSel == 2'(i)) && (wrRw != RW_LATCH);
		assign latchCmd = ctrlWr && (wrSel == 2'(i)) && (wrRw == RW_LATCH);
		assign rbHit = ctrlWr && (wrSel == SEL_READBACK) && ioReq.wdata[RB_CNT_LSB + i];
		assign rbCount = rbHit && !ioReq.wdata[RB_NOCOUNT_BIT];
		assign rbStat = rbHit && !ioReq.wdata[RB_NOSTAT_BIT];

		assign md = normMode(ctrlR.mode);
		assign wrMd = normMode(ioReq.wdata[MODE_MSB:MODE_LSB]);
		assign dec1 = cntDec(ceR, ctrlR.bcd);
		assign dec2 = cntDec(dec1, ctrlR.bcd);
		assign isStrobe = (md == MODE_SWSTROBE) || (md == MODE_HWSTROBE);
		assign stbRun = isStrobe && (gateS2[i] || md == MODE_HWSTROBE);

		// Count bytes assemble in the programmed order; a single-byte write clears the other byte.
		assign cntDone = cntWr && ((ctrlR.rw != RW_BOTH) || wrHighR);
		assign crNew = (ctrlR.rw == RW_LSB_ONLY) ? {8'h00, ioReq.wdata} :
			(ctrlR.rw == RW_MSB_ONLY) ? {ioReq.wdata, 8'h00} :
			wrHighR ? {ioReq.wdata, crR[7:0]} : {crR[15:8], ioReq.wdata};

		// Gate edges reload modes 2 and 3 and trigger modes 1 and 5.
		assign trigMd = gateTrig(md);
		assign reloadMd = autoReload(md);
		assign loadNow = loadR || (trigR && ((armR && trigMd) || (runR && reloadMd)));
		// A running rate or square counter keeps its old count until the next reload.
		assign loadOnCnt = loadOnWrite(md) || (!runR && reloadMd);

		// Status first, then a latched count, else the live count.
		assign rdSrc = olValidR ? olR : ceR;
		assign rdHigh = (ctrlR.rw == RW_MSB_ONLY) || ((ctrlR.rw == RW_BOTH) && rdHighR);
		assign rdLast = (ctrlR.rw != RW_BOTH) || rdHighR;
		assign rdByte[i] = stValidR ? stR : pickByte(rdSrc, rdHigh);
		assign counterOut[i] = outR;

		// Host-side decode of the latch and status commands.
		assign latchGo = (latchCmd || rbCount) && !olValidR;
		assign statGo = rbStat && !stValidR;
		assign stNew = {outR, nullR, ctrlR};

		always_ff @(posedge core_clk or posedge sys_rst) begin
			if (sys_rst) begin
				ctrlR <= CTRL_RESET;
				crR <= COUNT_RESET;
				ceR <= COUNT_RESET;
				olR <= COUNT_RESET;
				stR <= BYTE_RESET;
				olValidR <= 1'b0;
				stValidR <= 1'b0;
				wrHighR <= 1'b0;
				rdHighR <= 1'b0;
				nullR <= 1'b0;
				loadR <= 1'b0;
				armR <= 1'b0;
				runR <= 1'b0;
				outR <= 1'b0;
				trigR <= 1'b0;
			end else begin
				// Counting side; bus writes below take precedence in the same cycle.
				if (tick[i]) begin
					trigR <= 1'b0;
					if (loadNow) begin
						ceR <= crR;
						nullR <= 1'b0;
						loadR <= 1'b0;
						runR <= 1'b1;
						if (md == MODE_ONESHOT) begin
							outR <= 1'b0;
						end
					end else if (runR) begin
						case (md)
							MODE_EOC: begin
								if (gateS2[i]) begin
									ceR <= dec1;
									if (dec1 == 16'h0000) begin
										outR <= 1'b1;
									end
								end
							end
							MODE_ONESHOT: begin
								ceR <= dec1;
								if (dec1 == 16'h0000) begin
									outR <= 1'b1;
								end
							end
							MODE_RATE: begin
								if (!gateS2[i]) begin
									outR <= 1'b1;
								end else if (ceR == 16'h0001) begin
									ceR <= crR;
									nullR <= 1'b0;
									outR <= 1'b1;
								end else begin
									ceR <= dec1;
									outR <= dec1 != 16'h0001;
								end
							end
							MODE_SQUARE: begin
								if (!gateS2[i]) begin
									outR <= 1'b1;
								end else if (dec1 == 16'h0000 || dec2 == 16'h0000) begin
									ceR <= crR;
									nullR <= 1'b0;
									outR <= !outR;
								end else begin
									ceR <= dec2;
								end
							end
							default: begin
								// Strobes pulse low for one count clock, then stop.
								if (stbRun) begin
									ceR <= dec1;
									outR <= dec1 != 16'h0000;
									if (!outR) begin
										outR <= 1'b1;
										runR <= 1'b0;
									end
								end
							end
						endcase
					end
				end
				// A gate edge in the same cycle as a consumed tick is kept.
				if (gateRise[i]) begin
					trigR <= 1'b1;
				end

				// Host side.
				if (ctrlHit) begin
					ctrlR <= ctrl_t'(ioReq.wdata[RW_MSB:BCD_BIT]);
					wrHighR <= 1'b0;
					rdHighR <= 1'b0;
					olValidR <= 1'b0;
					nullR <= 1'b1;
					loadR <= 1'b0;
					armR <= 1'b0;
					runR <= 1'b0;
					outR <= wrMd != MODE_EOC;
				end else if (cntWr) begin
					crR <= crNew;
					if (ctrlR.rw == RW_BOTH) begin
						wrHighR <= !wrHighR;
					end
					if (cntDone) begin
						nullR <= 1'b1;
						loadR <= loadOnCnt;
						armR <= 1'b1;
						if (md == MODE_EOC) begin
							outR <= 1'b0;
						end
					end
				end
				if (cntRd) begin
					if (stValidR) begin
						stValidR <= 1'b0;
					end else begin
						if (ctrlR.rw == RW_BOTH) begin
							rdHighR <= !rdHighR;
						end
						if (rdLast) begin
							olValidR <= 1'b0;
						end
					end
				end
				// Repeated latch commands are ignored until the frozen count is read.
				if (latchGo) begin
					olR <= ceR;
					olValidR <= 1'b1;
				end
				if (statGo) begin
					stR <= stNew;
					stValidR <= 1'b1;
				end
			end
		end
	end

endmodule // interval_timer

// >>> interval_timer_assertions.sv
// Port checker of the interval timer.
`timescale 1ns/1ps

module interval_timer_assertions
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Host port
	input timer_pkg::io_req_t ioReq,
	input logic [7:0] ioRdData,
	input logic ioRdValid,
	// Pins
	input logic [timer_pkg::NUM_COUNTERS-1:0] countClkPin,
	input logic [timer_pkg::NUM_COUNTERS-1:0] gatePin,
	input logic [timer_pkg::NUM_COUNTERS-1:0] counterOut
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////
	sequence ctrlWr0;
		ioReq.wr && ioReq.addr == CTRL_PORT && ioReq.wdata[7:4] inside {4'h1, 4'h2, 4'h3};
	endsequence
	sequence rdOff;
		ioReq.rd && (ioReq.addr < CNT0_PORT || ioReq.addr > CTRL_PORT);
	endsequence
	AST_VALID_PULSE: assert property (ioReq.rd |=> ioRdValid)
		else $error("read not answered");
	AST_VALID_CAUSE: assert property (ioRdValid |-> $past(ioReq.rd))
		else $error("stray read valid");
	AST_DATA_HOLD: assert property (!ioReq.rd |=> $stable(ioRdData))
		else $error("read data moved");
	AST_CTRL_RD_ZERO: assert property (ioReq.rd && ioReq.addr == CTRL_PORT |=>
		ioRdData == UNMAPPED_READ) else $error("control port readable");
	AST_UNMAPPED_ZERO: assert property (rdOff |=> ioRdData == UNMAPPED_READ)
		else $error("unmapped read not zero");
	AST_OUT_MODE0: assert property (ctrlWr0 ##0 ioReq.wdata[3:1] == 3'h0
		|-> ##[1:3] !counterOut[0]) else $error("mode 0 out not low");
	AST_OUT_HIGH: assert property (ctrlWr0 ##0 ioReq.wdata[3:1] != 3'h0
		|-> ##[1:3] counterOut[0]) else $error("out not high");
	AST_RESET_IDLE: assert property (disable iff (1'b0) sys_rst
		|-> !ioRdValid && counterOut == '0) else $error("outputs active in reset");
endmodule // interval_timer_assertions

bind interval_timer interval_timer_assertions chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
	.ioReq(ioReq), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
	.countClkPin(countClkPin), .gatePin(gatePin), .counterOut(counterOut));

// >>> host_io_model.sv
// Host processor model issuing I/O port cycles.
`timescale 1ns/1ps

module host_io_model
	import timer_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Port cycle
	output timer_pkg::io_req_t ioReq
);
	initial ioReq = '0;
	////////////////////////////////
	// After the strobe the bus shows the inverse, so a stale value never passes.
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		#2;
		ioReq = '{wr: wr, rd: !wr, addr: addr, wdata: data};
		@(posedge core_clk);
		#2;
		ioReq = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
	endtask
endmodule // host_io_model

// >>> interval_timer_tb.sv
// Self-checking testbench of the interval timer.
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module interval_timer_tb;
	import timer_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b0;
	io_req_t ioReq;
	logic [7:0] ioRdData;
	logic ioRdValid;
	logic [NUM_COUNTERS-1:0] countClkPin = '0;
	logic [NUM_COUNTERS-1:0] gatePin = '1;
	logic [NUM_COUNTERS-1:0] counterOut;
	logic [7:0] expQ[$];
	logic [7:0] expV;
	int mismatches = 0;
	int nTests = 0;
	always #12.5 core_clk = ~core_clk;
	host_io_model host_u (.core_clk(core_clk), .ioReq(ioReq));
	interval_timer dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .ioReq(ioReq),
		.ioRdData(ioRdData), .ioRdValid(ioRdValid), .countClkPin(countClkPin),
		.gatePin(gatePin), .counterOut(counterOut));
	////////////////////////////////
	function automatic logic [31:0] nextRnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		host_u.xfer(1'b0, a, 8'h00);
	endtask
	// Pin pulses last several cycles because the pins pass a three-stage synchroniser.
	task automatic tick(input int c);
		countClkPin[c] = 1'b1;
		repeat (4) @(posedge core_clk);
		#2;
		countClkPin[c] = 1'b0;
		repeat (6) @(posedge core_clk);
		#2;
	endtask
	task automatic printVerdict();
		$display("mismatches=%0d tests=%0d", mismatches, nTests);
		if (mismatches == 0 && nTests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (ioRdValid === 1'b1) begin
			expV = (expQ.size() != 0) ? expQ.pop_front() : ~ioRdData;
			`CHK(ioRdData, expV)
		end
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		printVerdict();
	end
	initial begin
		logic [31:0] r;
		logic [7:0] st;
		int c;
		r = 32'h1ed2;
		// A real rising edge of reset clears the flops before the first clock edge.
		#1;
		sys_rst = 1'b1;
		repeat (10) @(posedge core_clk);
		#2;
		sys_rst = 1'b0;
		rd(CTRL_PORT, UNMAPPED_READ);
		rd(8'h47, UNMAPPED_READ);
		// Every mode code, x10 and x11 included, spread over the three counters in turn.
		for (int i = 0; i < 8; i++) begin
			c = i % 3;
			r = nextRnd(r);
			st = {(i != 0), 1'b1, r[0], !r[0], i[2:0], r[1]};
			wr(CTRL_PORT, {c[1:0], st[5:0]});
			wr(CNT0_PORT + c[7:0], r[15:8]);
			wr(CTRL_PORT, 8'he0 | (8'h02 << c));
			rd(CNT0_PORT + c[7:0], st);
		end
		r = nextRnd(r);
		wr(CTRL_PORT, 8'h70);
		wr(CNT1_PORT, r[7:0]);
		wr(CNT1_PORT, r[15:8]);
		tick(1);
		wr(CTRL_PORT, 8'hc4);
		rd(CNT1_PORT, 8'h30);
		for (int k = 0; k < 2; k++) begin
			rd(CNT1_PORT, r[7:0]);
			rd(CNT1_PORT, r[15:8]);
			wr(CTRL_PORT, 8'h40);
		end
		for (int j = 1; j < 3; j++) begin
			r = nextRnd(r);
			wr(CTRL_PORT, 8'h80 | (j[7:0] << 4));
			wr(CNT2_PORT, r[7:0]);
			tick(2);
			wr(CTRL_PORT, 8'h80);
			rd(CNT2_PORT, r[7:0]);
		end
		// Mode 0 in binary on counter 0: out stays low until the count runs out.
		wr(CTRL_PORT, 8'h10);
		wr(CNT0_PORT, 8'h03);
		repeat (3) tick(0);
		`CHK(counterOut[0], 1'b0)
		wr(CTRL_PORT, 8'h00);
		rd(CNT0_PORT, 8'h01);
		tick(0);
		`CHK(counterOut[0], 1'b1)
		wr(CTRL_PORT, 8'he2);
		rd(CNT0_PORT, 8'h90);
		rd(CNT0_PORT, 8'h00);
		// In BCD a count of 10 steps down to 09, not to 0f.
		wr(CTRL_PORT, 8'h11);
		wr(CNT0_PORT, 8'h10);
		repeat (2) tick(0);
		wr(CTRL_PORT, 8'h00);
		rd(CNT0_PORT, 8'h09);
		for (int w = 0; w < 20 && expQ.size() != 0; w++) begin
			@(posedge core_clk);
		end
		if (expQ.size() != 0) begin
			mismatches++;
		end
		printVerdict();
	end
endmodule // interval_timer_tb
